// ### test/disk_side_model.sv
// disk side model: data separator window and bit stream
`timescale 1ns/100ps
`default_nettype none
module disk_side_model (
  // control from the bench
  input wire logic i_core_clk,
  input wire logic i_start,
  input wire logic [7:0] i_byte,
  input wire logic [7:0] i_bit_cycles,
  // separator pins
  output logic o_separator_window,
  output logic o_separator_bit_value
);
  initial
  begin
    o_separator_window = 1'b0;
    o_separator_bit_value = 1'b0;
  end
  // window stands still between frames; data toggles so a stale bit never looks valid
  always @(posedge i_core_clk)
  begin
    if (!i_start)
      o_separator_bit_value <= ~o_separator_bit_value;
    else
    begin
      // msb first, bit held across its whole window
      for (int b = 7; b >= 0; b--)
      begin
        o_separator_bit_value <= i_byte[b];
        repeat (i_bit_cycles) @(posedge i_core_clk);
        o_separator_window <= 1'b1;
        repeat (i_bit_cycles) @(posedge i_core_clk);
        o_separator_window <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/floppy_ctrl_bus_datapath_tb_top.sv
// testbench top of the floppy controller bus datapath
`timescale 1ns/100ps
`default_nettype none
module floppy_ctrl_bus_datapath_tb_top;
  localparam logic [5:0] BLK = fdc_pkg::BOARD_BLOCK_DEF;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic i_mem_rd = 1'b0;
  logic i_dd_detect = 1'b0;
  logic i_sector_pulse = 1'b0;
  logic i_motor_on_req_n = 1'b1;
  logic dsk_start = 1'b0;
  logic [7:0] dsk_byte = 8'h00;
  logic [7:0] dsk_cycles = 8'h08;
  logic window, bitval, drive_n, ready, wpulse, wgate, precomp, motor, side, sdir, step, ddflag;
  logic [7:0] boot_addr, data_in, rd;
  logic [3:0] drive_sel;
  logic drv;
  logic [7:0] b;
  int n_errors = 0;
  int tests_run = 0;
  int cyc, np;
  always #2 i_core_clk = ~i_core_clk;
  floppy_ctrl_bus_datapath #(.MOTOR_OFF_TICKS(20)) dut (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
    .i_addr(i_addr), .i_mem_rd(i_mem_rd), .i_boot_data(boot_addr ^ 8'h5A),
    .o_boot_addr(boot_addr), .o_data_in(data_in), .o_input_bus_drive_n(drive_n),
    .o_processor_ready_line(ready), .i_separator_window(window),
    .i_separator_bit_value(bitval), .i_dd_detect(i_dd_detect),
    .i_sector_pulse(i_sector_pulse), .i_motor_on_req_n(i_motor_on_req_n),
    .o_write_pulse(wpulse), .o_write_gate(wgate), .o_precomp_enable(precomp),
    .o_motor_on(motor), .o_drive_select(drive_sel), .o_side_select(side),
    .o_step_dir(sdir), .o_step(step), .o_double_density_flag(ddflag));
  disk_side_model disk (
    .i_core_clk(i_core_clk), .i_start(dsk_start), .i_byte(dsk_byte),
    .i_bit_cycles(dsk_cycles), .o_separator_window(window),
    .o_separator_bit_value(bitval));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until the ready edge, data taken at that same edge
  task automatic bus_ref(input logic [1:0] sub, input logic [7:0] low, input int lim);
    cyc = 0;
    @(posedge i_core_clk);
    i_addr <= {BLK, sub, low};
    i_mem_rd <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      cyc++;
    end
    while (ready !== 1'b1 && cyc < lim);
    rd = data_in;
    drv = drive_n;
    i_mem_rd <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic count_pulses;
    np = 0;
    repeat (5000)
    begin
      @(posedge i_core_clk);
      if (wpulse === 1'b1) np++;
    end
  endtask
  function automatic logic [7:0] stat(input logic sf, dd, mo, wr);
    return {sf, 1'b0, dd, mo, wr, 3'h0};
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'hE58D));
    wait_clk(20);
    i_sys_rst <= 1'b0;
    wait_clk(5);
    check({ready, drive_n, motor, wgate, ddflag, drive_sel, data_in}, 24'h008000);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      b = $urandom;
      bus_ref(fdc_pkg::SUB_ORDER, b, 20);
      check(cyc, 2);
      check({drive_sel, side, sdir, step}, {b[3:0], b[6], b[5], b[4]});
      // back to back reference, request low for two clock edges, one more than the minimum spacing
      bus_ref(fdc_pkg::SUB_ORDER, ~b, 20);
      check({drive_sel, side, sdir, step}, {~b[3:0], ~b[6], ~b[5], ~b[4]});
    end
    // a foreign block must never answer
    @(posedge i_core_clk);
    i_addr <= {BLK ^ 6'h10, 10'h285};
    i_mem_rd <= 1'b1;
    cyc = 0;
    repeat (20) if (ready === 1'b1) cyc++; else @(posedge i_core_clk);
    i_mem_rd <= 1'b0;
    check(cyc, 0);
    wait_clk(2);
    for (int i = 0; i < 3; i++)
    begin
      b = $urandom;
      bus_ref(fdc_pkg::SUB_PROM, b, 20);
      check(cyc, 3);
      check({drv, rd}, {1'b0, b ^ 8'h5A});
    end
    $display("test decode done");
    bus_ref(fdc_pkg::SUB_CMD, 8'h15, 20);
    check({cyc[3:0], drv}, 5'h04);
    bus_ref(fdc_pkg::SUB_CMD, 8'h10, 20);
    check(rd, stat(0, 0, 1, 0));
    wait_clk(2000);
    bus_ref(fdc_pkg::SUB_CMD, 8'h05, 20);
    wait_clk(2000);
    check(motor, 1'b1);
    wait_clk(1000);
    check(motor, 1'b0);
    i_motor_on_req_n <= 1'b0;
    wait_clk(10);
    i_motor_on_req_n <= 1'b1;
    wait_clk(2000);
    check(motor, 1'b1);
    wait_clk(1000);
    check(motor, 1'b0);
    $display("test motor done");
    i_sector_pulse <= 1'b1;
    wait_clk(10);
    i_sector_pulse <= 1'b0;
    wait_clk(10);
    bus_ref(fdc_pkg::SUB_CMD, 8'h30, 20);
    check(rd, stat(1, 0, 0, 0));
    bus_ref(fdc_pkg::SUB_CMD, 8'h11, 20);
    bus_ref(fdc_pkg::SUB_CMD, 8'h10, 20);
    check(rd, 8'h00);
    i_dd_detect <= 1'b1;
    wait_clk(10);
    bus_ref(fdc_pkg::SUB_CMD, 8'h20, 20);
    check({ddflag, rd}, {1'b1, stat(0, 1, 0, 0)});
    i_dd_detect <= 1'b0;
    // detect pin lags through the filter; set would win over the reset
    wait_clk(10);
    bus_ref(fdc_pkg::SUB_CMD, 8'h07, 20);
    bus_ref(fdc_pkg::SUB_CMD, 8'h00, 20);
    check({ddflag, drv}, 2'h1);
    $display("test flags done");
    for (int i = 0; i < 2; i++)
    begin
      dsk_cycles <= (i == 0) ? 8'h08 : 8'h28;
      dsk_byte <= $urandom;
      dsk_start <= 1'b1;
      @(posedge i_core_clk);
      dsk_start <= 1'b0;
      bus_ref(fdc_pkg::SUB_CMD, 8'h40, 8000);
      check(rd, dsk_byte);
      check(cyc > 15 * dsk_cycles, 1'b1);
    end
    $display("test read done");
    bus_ref(fdc_pkg::SUB_ORDER, 8'h21, 20);
    bus_ref(fdc_pkg::SUB_CMD, 8'h06, 20);
    wait_clk(10);
    check({wgate, precomp}, 2'h3);
    count_pulses();
    check(np >= 9 && np <= 11, 1'b1);
    bus_ref(fdc_pkg::SUB_WRITE, 8'h00, 20);
    bus_ref(fdc_pkg::SUB_WRITE, 8'hFF, 6000);
    check(cyc > 2 && cyc < 6000, 1'b1);
    count_pulses();
    check(np >= 12, 1'b1);
    bus_ref(fdc_pkg::SUB_CMD, 8'h20, 20);
    check(rd, stat(0, 0, 0, 1));
    bus_ref(fdc_pkg::SUB_CMD, 8'h07, 20);
    wait_clk(5);
    check({wgate, drive_sel}, 5'h00);
    bus_ref(fdc_pkg::SUB_ORDER, 8'hA0, 20);
    bus_ref(fdc_pkg::SUB_CMD, 8'h06, 20);
    count_pulses();
    check(np >= 19 && np <= 21, 1'b1);
    i_sector_pulse <= 1'b1;
    wait_clk(10);
    i_sector_pulse <= 1'b0;
    wait_clk(20);
    check(wgate, 1'b0);
    $display("test write done");
    stop_test();
  end
  initial
  begin
    wait_clk(80000);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire

// ### verilog/fdc_pkg.sv
// shared constants and carrier types of the floppy controller datapath
`default_nettype none
package fdc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_HZ = 250_000_000;
  localparam int TICK_HZ = 2_000_000;
  localparam int CORE_PER_TICK = CORE_HZ / TICK_HZ;
  localparam int MOTOR_OFF_S = 12;
  localparam int MOTOR_OFF_TICKS = MOTOR_OFF_S * TICK_HZ;
  localparam int SD_HALF_TICKS = 2;
  localparam int DD_HALF_TICKS = 1;
  // ****************************************
  // address map
  // ****************************************
  localparam logic [5:0] BOARD_BLOCK_DEF = 6'h3A;
  localparam logic [1:0] SUB_PROM = 2'h0;
  localparam logic [1:0] SUB_WRITE = 2'h1;
  localparam logic [1:0] SUB_ORDER = 2'h2;
  localparam logic [1:0] SUB_CMD = 2'h3;
  localparam logic [3:0] DM_A = 4'h1;
  localparam logic [3:0] DM_B = 4'h2;
  localparam logic [3:0] DM_C = 4'h3;
  localparam logic [3:0] DM_READ = 4'h4;
  localparam logic [3:0] CC_CLR_SF = 4'h1;
  localparam logic [3:0] CC_MOTOR = 4'h5;
  localparam logic [3:0] CC_WRITE = 4'h6;
  localparam logic [3:0] CC_RESET = 4'h7;
  localparam logic [4:0] PIN_RST = 5'h01;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic dd;
    logic ss;
    logic dp;
    logic st;
    logic [3:0] ds;
  } order_s;
  localparam order_s ORDER_RESET = 8'h00;
  typedef struct packed {
    logic hit;
    logic [1:0] sub;
    logic [7:0] low;
  } decode_s;
endpackage
`default_nettype wire

// ### verilog/floppy_ctrl_bus_datapath.sv
// floppy controller bus datapath: decode, write/read shifters, status mux, motor timer
// How it works
// RULE1: the upper address byte goes through the board decode and only a block match responds.
// RULE2: the low address byte of a selected reference carries data or control per the decode.
// RULE3: a write-byte reference loads its low address byte into the write shift register.
// RULE4: a write byte meeting a full write shifter stalls the processor until it empties.
// RULE5: output data is FM coded in single density, MFM in double, with precompensation control.
// RULE6: the read shifter takes the separator data bit on each separator window edge; the code shifts on the rising window edge only.
// RULE7: read references drive the read byte or a status byte onto the input bus.
// RULE8: the double density flag is set whenever double density data is detected.
// RULE9: motors keep running a full timeout after the motor request is released, then stop.
// RULE10: a read of the motor command location alone starts the motors and selects drives; the code only starts the motors, drives come from the order byte.
// RULE11: every motor request restarts the timeout from its full value.
// RULE12: the two bits below the board bits pick bootstrap read, write byte, order or command.
// RULE13: a read-data command waits until the read shifter holds a whole byte.
// RULE14: the mux field picks status A, B, C or read data for the input bus.
// RULE15: sequencing runs on a 2 MHz tick taken from the core clock.
`timescale 1ns/100ps
`default_nettype none
module floppy_ctrl_bus_datapath #(
  parameter logic [5:0] BOARD_BLOCK = fdc_pkg::BOARD_BLOCK_DEF,
  parameter int MOTOR_OFF_TICKS = fdc_pkg::MOTOR_OFF_TICKS
) (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // processor bus
  input wire logic [15:0] i_addr,
  input wire logic i_mem_rd,
  input wire logic [7:0] i_boot_data,
  output logic [7:0] o_boot_addr,
  output logic [7:0] o_data_in,
  output logic o_input_bus_drive_n,
  output logic o_processor_ready_line,
  // drive side pins
  input wire logic i_separator_window,
  input wire logic i_separator_bit_value,
  input wire logic i_dd_detect,
  input wire logic i_sector_pulse,
  input wire logic i_motor_on_req_n,
  output logic o_write_pulse,
  output logic o_write_gate,
  output logic o_precomp_enable,
  output logic o_motor_on,
  output logic [3:0] o_drive_select,
  output logic o_side_select,
  output logic o_step_dir,
  output logic o_step,
  output logic o_double_density_flag
);
  localparam int NPIN = 5;
  localparam int TMR_W = $clog2(MOTOR_OFF_TICKS + 1);
  localparam logic [TMR_W-1:0] TMR_FULL = TMR_W'(MOTOR_OFF_TICKS);
  localparam logic [6:0] DIV_END = 7'(fdc_pkg::CORE_PER_TICK - 1);
  localparam logic [1:0] SD_END = 2'(fdc_pkg::SD_HALF_TICKS - 1);
  localparam logic [1:0] DD_END = 2'(fdc_pkg::DD_HALF_TICKS - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_BOOT, ST_WAIT_WR, ST_WAIT_RD} bus_state_e;
  bus_state_e state;
  bus_state_e next_state;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1;
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] pin;
  logic [NPIN-1:0] pin_q;
  assign pin_raw = {i_separator_window, i_separator_bit_value, i_dd_detect, i_sector_pulse,
                    i_motor_on_req_n};
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      s1 <= fdc_pkg::PIN_RST;
      s2 <= fdc_pkg::PIN_RST;
      s3 <= fdc_pkg::PIN_RST;
      pin_q <= fdc_pkg::PIN_RST;
    end
    else if (i_ce)
    begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      pin_q <= pin;
    end
  end
  // glitch filter: a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      always_ff @(posedge i_core_clk)
      begin
        if (i_sys_rst)
          pin[gi] <= fdc_pkg::PIN_RST[gi];
        else if (i_ce && s2[gi] == s3[gi])
          pin[gi] <= s3[gi];
      end
    end
  endgenerate
  wire win_rise = pin[4] & ~pin_q[4];
  wire separator_bit_value = pin[3];
  wire dd_det = pin[2];
  wire sector_rise = pin[1] & ~pin_q[1];
  wire motor_req = ~pin[0];

  // ****************************************
  // 2 MHz sequencing tick
  // ****************************************
  logic [6:0] div_cnt;
  logic tick;
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      div_cnt <= 7'h00;
      tick <= 1'b0;
    end
    else if (i_ce)
    begin
      div_cnt <= (div_cnt == DIV_END) ? 7'h00 : div_cnt + 7'h01; // [RULE15]
      tick <= (div_cnt == DIV_END); // [RULE15]
    end
  end

  // ****************************************
  // board decode
  // ****************************************
  function automatic fdc_pkg::decode_s board_decode_table(input logic [15:0] a);
    fdc_pkg::decode_s d;
    d.hit = (a[15:10] == BOARD_BLOCK); // [RULE1]
    d.sub = a[9:8]; // [RULE12]
    d.low = a[7:0]; // [RULE2]
    return d;
  endfunction
  fdc_pkg::decode_s dec;
  assign dec = board_decode_table(i_addr);
  logic rd_q;
  wire [5:0] board_select_bits = i_addr[15:10];
  wire acc = i_mem_rd & ~rd_q & (state == ST_IDLE) & dec.hit; // [RULE1]
  wire is_write = acc && dec.sub == fdc_pkg::SUB_WRITE; // [RULE12]
  wire is_order = acc && dec.sub == fdc_pkg::SUB_ORDER; // [RULE12]
  wire is_cmd = acc && dec.sub == fdc_pkg::SUB_CMD; // [RULE12]
  wire [3:0] input_mux_select = dec.low[7:4];
  wire [3:0] cmd_code = dec.low[3:0];
  wire cmd_motor = is_cmd && cmd_code == fdc_pkg::CC_MOTOR; // [RULE10]
  wire cmd_reset = is_cmd && cmd_code == fdc_pkg::CC_RESET;
  wire cmd_clr_sf = is_cmd && cmd_code == fdc_pkg::CC_CLR_SF;
  wire cmd_write = is_cmd && cmd_code == fdc_pkg::CC_WRITE;
  wire cmd_read = is_cmd && input_mux_select == fdc_pkg::DM_READ;

  // ****************************************
  // status and flags
  // ****************************************
  logic sector_flag;
  logic double_density_flag;
  logic motor_on;
  logic write_active;
  fdc_pkg::order_s order;
  logic [TMR_W-1:0] timer;
  wire [7:0] status_a = {sector_flag, 1'b0, double_density_flag, motor_on, 4'h0};
  wire [7:0] status_b = {sector_flag, 1'b0, double_density_flag, motor_on, write_active, 3'h0};
  wire [7:0] status_c = {sector_flag, 1'b0, double_density_flag, motor_on, 4'h0};
  wire mux_drive = input_mux_select == fdc_pkg::DM_A || input_mux_select == fdc_pkg::DM_B
                   || input_mux_select == fdc_pkg::DM_C;
  wire [7:0] mux_data = (input_mux_select == fdc_pkg::DM_A) ? status_a : // [RULE14]
                        (input_mux_select == fdc_pkg::DM_B) ? status_b :
                        (input_mux_select == fdc_pkg::DM_C) ? status_c : 8'h00;
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      sector_flag <= 1'b0;
      double_density_flag <= 1'b0;
      write_active <= 1'b0;
      order <= fdc_pkg::ORDER_RESET;
    end
    else if (i_ce)
    begin
      // set wins over clear
      if (sector_rise)
        sector_flag <= 1'b1;
      else if (cmd_clr_sf || cmd_reset)
        sector_flag <= 1'b0;
      if (dd_det)
        double_density_flag <= 1'b1; // [RULE8]
      else if (cmd_reset)
        double_density_flag <= 1'b0;
      if (cmd_write)
        write_active <= 1'b1;
      else if (sector_rise || cmd_reset)
        write_active <= 1'b0;
      if (cmd_reset)
        order <= fdc_pkg::ORDER_RESET;
      else if (is_order)
        order <= fdc_pkg::order_s'(dec.low); // [RULE2] [RULE10]
    end
  end
  assign o_drive_select = order.ds;
  assign o_side_select = order.ss;
  assign o_step_dir = order.dp;
  assign o_step = order.st;
  assign o_double_density_flag = double_density_flag;
  assign o_motor_on = motor_on;

  // ****************************************
  // motor timeout, counted in 2 MHz ticks
  // ****************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      motor_on <= 1'b0;
      timer <= '0;
    end
    else if (i_ce)
    begin
      if (cmd_reset)
      begin
        motor_on <= 1'b0;
        timer <= '0;
      end
      else if (motor_req || cmd_motor)
      begin
        motor_on <= 1'b1; // [RULE10]
        timer <= TMR_FULL; // [RULE11]
      end
      else if (tick && motor_on)
      begin
        if (timer == '0)
          motor_on <= 1'b0; // [RULE9]
        else
          timer <= timer - 1'b1; // [RULE9]
      end
    end
  end

  // ****************************************
  // write shifter and encoder
  // ****************************************
  logic [7:0] wsr;
  logic [7:0] wr_pend;
  logic [2:0] wsr_cnt;
  logic wsr_full;
  logic [1:0] half_cnt;
  logic phase;
  logic cur_bit;
  wire wsr_load = !wsr_full && (is_write || state == ST_WAIT_WR); // [RULE4]
  wire [7:0] load_byte = is_write ? dec.low : wr_pend; // [RULE3]
  wire [1:0] half_end = order.dd ? DD_END : SD_END;
  wire half_done = write_active && tick && half_cnt == half_end;
  wire bit_edge = half_done && phase;
  // an empty shifter feeds zeros, so the gap stays a clean zero stream
  wire next_bit = wsr_full & wsr[7];
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      wsr <= 8'h00;
      wr_pend <= 8'h00;
      wsr_cnt <= 3'h0;
      wsr_full <= 1'b0;
      half_cnt <= 2'h0;
      phase <= 1'b1;
      cur_bit <= 1'b0;
      o_write_pulse <= 1'b0;
      o_write_gate <= 1'b0;
      o_precomp_enable <= 1'b0;
    end
    else if (i_ce)
    begin
      o_write_pulse <= 1'b0;
      o_write_gate <= write_active;
      o_precomp_enable <= write_active & order.dp; // [RULE5]
      if (is_write)
        wr_pend <= dec.low;
      if (wsr_load)
      begin
        wsr <= load_byte; // [RULE3]
        wsr_full <= 1'b1;
        wsr_cnt <= 3'h0;
      end
      else if (bit_edge && wsr_full)
      begin
        wsr <= {wsr[6:0], 1'b0};
        wsr_cnt <= wsr_cnt + 3'h1;
        wsr_full <= (wsr_cnt != 3'h7);
      end
      if (!write_active)
      begin
        half_cnt <= 2'h0;
        phase <= 1'b1;
      end
      else if (tick)
        half_cnt <= half_done ? 2'h0 : half_cnt + 2'h1;
      if (half_done)
      begin
        phase <= ~phase;
        if (phase)
        begin
          cur_bit <= next_bit;
          // FM clocks every cell; MFM only between two zeros
          o_write_pulse <= order.dd ? (~cur_bit & ~next_bit) : 1'b1; // [RULE5]
        end
        else
          o_write_pulse <= cur_bit; // [RULE5]
      end
    end
  end

  // ****************************************
  // read shifter
  // ****************************************
  logic [7:0] rsr;
  logic [7:0] rd_byte;
  logic [2:0] rcnt;
  logic rd_full;
  wire rd_take = (cmd_read || state == ST_WAIT_RD) && rd_full;
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      rsr <= 8'h00;
      rd_byte <= 8'h00;
      rcnt <= 3'h0;
      rd_full <= 1'b0;
    end
    else if (i_ce)
    begin
      if (win_rise)
      begin
        rsr <= {rsr[6:0], separator_bit_value}; // [RULE6]
        rcnt <= rcnt + 3'h1;
        if (rcnt == 3'h7)
          rd_byte <= {rsr[6:0], separator_bit_value};
      end
      if (win_rise && rcnt == 3'h7)
        rd_full <= 1'b1;
      else if (rd_take)
        rd_full <= 1'b0;
    end
  end

  // ****************************************
  // processor handshake
  // ****************************************
  logic next_ready;
  logic next_drive;
  logic [7:0] next_data;
  always_comb
  begin
    next_state = state;
    next_ready = 1'b0;
    next_drive = 1'b0;
    next_data = o_data_in;
    case (state)
      ST_IDLE:
        if (acc)
        begin
          if (dec.sub == fdc_pkg::SUB_PROM)
            next_state = ST_BOOT;
          else if (dec.sub == fdc_pkg::SUB_WRITE && wsr_full)
            next_state = ST_WAIT_WR; // [RULE4]
          else if (cmd_read && !rd_full)
            next_state = ST_WAIT_RD; // [RULE13]
          else
          begin
            next_ready = 1'b1;
            next_drive = cmd_read || (is_cmd && mux_drive); // [RULE7]
            next_data = cmd_read ? rd_byte : mux_data; // [RULE7] [RULE14]
          end
        end
      ST_BOOT:
      begin
        next_state = ST_IDLE;
        next_ready = 1'b1;
        next_drive = 1'b1;
        next_data = i_boot_data;
      end
      ST_WAIT_WR:
        if (!wsr_full)
        begin
          next_state = ST_IDLE;
          next_ready = 1'b1;
        end
      ST_WAIT_RD:
        if (rd_full)
        begin
          next_state = ST_IDLE;
          next_ready = 1'b1;
          next_drive = 1'b1;
          next_data = rd_byte; // [RULE13]
        end
      default:
        next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      state <= ST_IDLE;
      rd_q <= 1'b0;
      o_processor_ready_line <= 1'b0;
      o_input_bus_drive_n <= 1'b1;
      o_data_in <= 8'h00;
      o_boot_addr <= 8'h00;
    end
    else if (i_ce)
    begin
      state <= next_state;
      rd_q <= i_mem_rd;
      o_processor_ready_line <= next_ready;
      o_input_bus_drive_n <= ~next_drive;
      o_data_in <= next_data;
      if (acc && dec.sub == fdc_pkg::SUB_PROM)
        o_boot_addr <= dec.low;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence cmd_status_a_s;
    i_ce && is_cmd && input_mux_select == fdc_pkg::DM_A;
  endsequence
  sequence read_starved_s;
    i_ce && state == ST_WAIT_RD && !rd_full;
  endsequence
  board_select_a: assert property (i_ce && state == ST_IDLE && i_mem_rd && !rd_q && !dec.hit // [RULE1]
    |=> state == ST_IDLE && !o_processor_ready_line) else $error("foreign block answered");
  order_load_a: assert property (i_ce && is_order // [RULE12] [RULE2]
    |=> order == $past(i_addr[7:0]) && o_processor_ready_line) else $error("order not loaded");
  write_load_a: assert property (i_ce && is_write && !wsr_full // [RULE3]
    |=> wsr_full && wsr == $past(i_addr[7:0])) else $error("write byte not loaded");
  write_stall_a: assert property (i_ce && is_write && wsr_full // [RULE4]
    |=> !o_processor_ready_line && state == ST_WAIT_WR) else $error("write did not stall");
  fm_clock_a: assert property (i_ce && bit_edge && !order.dd // [RULE5]
    |=> o_write_pulse) else $error("fm clock pulse missing");
  read_shift_a: assert property (i_ce && win_rise // [RULE6]
    |=> rsr == {$past(rsr[6:0]), $past(separator_bit_value)}) else $error("read shift wrong");
  status_mux_a: assert property (cmd_status_a_s // [RULE7] [RULE14]
    |=> o_processor_ready_line && !o_input_bus_drive_n && o_data_in == $past(status_a))
    else $error("status a not driven");
  dd_flag_a: assert property (i_ce && dd_det |=> double_density_flag) // [RULE8]
    else $error("density flag not set");
  motor_off_a: assert property (i_ce && tick && motor_on && timer == '0 && !motor_req // [RULE9]
    && !cmd_motor |=> !o_motor_on) else $error("motor not stopped");
  motor_hold_a: assert property (i_ce && motor_on && timer != '0 && !cmd_reset // [RULE9]
    |=> o_motor_on ##1 (o_motor_on || $past(cmd_reset))) else $error("motor stopped early");
  motor_cmd_a: assert property (i_ce && cmd_motor // [RULE10]
    |=> o_motor_on && timer == TMR_FULL) else $error("motor command ignored");
  timer_restart_a: assert property (i_ce && motor_req && !cmd_reset // [RULE11]
    |=> timer == TMR_FULL) else $error("timeout not restarted");
  read_wait_a: assert property (read_starved_s |=> !o_processor_ready_line) // [RULE13]
    else $error("read released early");
  tick_rate_a: assert property (tick |=> !tick ##1 !tick) // [RULE15]
    else $error("tick too frequent");
endmodule
`default_nettype wire
